// >>> hdl/vofs_fast_switch.sv
// module: per-pixel source selector with fast switches and delay alignment
`timescale 1ns/1ps

module vofs_fast_switch (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// register port
	input  wire logic                  reg_wr_en,
	input  wire logic                  reg_rd_en,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata_q,
	// output format strap
	input  wire logic                  out_fmt_10bit,
	// sampled video in
	input  wire logic                  in_valid,
	output logic                       in_ready_q,
	input  wire vofs_pkg::vofs_video_t in_video,
	// overlay pins
	input  wire logic                  overlay_red_in,
	input  wire logic                  overlay_green_in,
	input  wire logic                  overlay_blue_in,
	input  wire logic                  overlay_switch_in,
	input  wire logic                  component_switch_in,
	// selected pixel out
	output logic                       out_valid_q,
	input  wire logic                  out_ready,
	output vofs_pkg::vofs_pixel_t      out_pixel_q,
	// input routing status
	output logic                       comb_input_q,
	output logic                       comp_is_ypbpr_q,
	output logic [1:0]                 comp_bank_q
);
	import vofs_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [VOFS_TAP_W-1:0] tap_of(
		input logic [6:0]              base,
		input logic [VOFS_SHIFT_W-1:0] shift
	);
		logic [6:0] sum;
		sum = base + {{2{shift[VOFS_SHIFT_W-1]}}, shift};
		return sum[VOFS_TAP_W-1:0];
	endfunction

	function automatic logic sw_active(
		input logic level,
		input logic pol
	);
		return level == pol;
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] input_source_select_q;
	logic [7:0] fast_switch_control_q;
	logic [7:0] overlay_switch_delay_q;
	logic [7:0] component_switch_delay_q;
	logic [7:0] overlay_color_delay_q;
	logic [7:0] component_video_delay_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			input_source_select_q    <= VOFS_RST_INPUT_SEL;
			fast_switch_control_q    <= VOFS_RST_FS_CTRL;
			overlay_switch_delay_q   <= VOFS_RST_SHIFT;
			component_switch_delay_q <= VOFS_RST_SHIFT;
			overlay_color_delay_q    <= VOFS_RST_SHIFT;
			component_video_delay_q  <= VOFS_RST_SHIFT;
		end else if (reg_wr_en) begin
			if (reg_addr == VOFS_ADDR_INPUT_SEL) begin
				input_source_select_q <= reg_wdata;
			end else if (reg_addr == VOFS_ADDR_FS_CTRL) begin
				fast_switch_control_q <= reg_wdata & VOFS_MASK_FS_CTRL;
			end else if (reg_addr == VOFS_ADDR_OSW_SHIFT) begin
				overlay_switch_delay_q <= reg_wdata & VOFS_MASK_SHIFT;
			end else if (reg_addr == VOFS_ADDR_CSW_SHIFT) begin
				component_switch_delay_q <= reg_wdata & VOFS_MASK_SHIFT;
			end else if (reg_addr == VOFS_ADDR_COLOR_SHIFT) begin
				overlay_color_delay_q <= reg_wdata & VOFS_MASK_SHIFT;
			end else if (reg_addr == VOFS_ADDR_COMP_SHIFT) begin
				component_video_delay_q <= reg_wdata & VOFS_MASK_SHIFT;
			end
		end
	end

	// read data, unmapped addresses read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd_en) begin
			if (reg_addr == VOFS_ADDR_INPUT_SEL) begin
				reg_rdata_q <= input_source_select_q;
			end else if (reg_addr == VOFS_ADDR_FS_CTRL) begin
				reg_rdata_q <= fast_switch_control_q;
			end else if (reg_addr == VOFS_ADDR_OSW_SHIFT) begin
				reg_rdata_q <= overlay_switch_delay_q;
			end else if (reg_addr == VOFS_ADDR_CSW_SHIFT) begin
				reg_rdata_q <= component_switch_delay_q;
			end else if (reg_addr == VOFS_ADDR_COLOR_SHIFT) begin
				reg_rdata_q <= overlay_color_delay_q;
			end else if (reg_addr == VOFS_ADDR_COMP_SHIFT) begin
				reg_rdata_q <= component_video_delay_q;
			end else begin
				reg_rdata_q <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	logic [2:0]              mode;
	logic                    osw_late;
	logic                    csw_late;
	logic                    osw_pol;
	logic                    csw_pol;
	logic [VOFS_SHIFT_W-1:0] overlay_switch_shift;
	logic [VOFS_SHIFT_W-1:0] component_switch_shift;
	logic [VOFS_SHIFT_W-1:0] overlay_color_shift;
	logic [VOFS_SHIFT_W-1:0] component_video_shift;

	assign mode     = fast_switch_control_q[VOFS_MODE_MSB:VOFS_MODE_LSB];
	assign osw_late = fast_switch_control_q[VOFS_OSW_EDGE_BIT];
	assign csw_late = fast_switch_control_q[VOFS_CSW_EDGE_BIT];
	assign osw_pol  = fast_switch_control_q[VOFS_OSW_POL_BIT];
	assign csw_pol  = fast_switch_control_q[VOFS_CSW_POL_BIT];
	assign overlay_switch_shift   = overlay_switch_delay_q[VOFS_SHIFT_W-1:0];
	assign component_switch_shift = component_switch_delay_q[VOFS_SHIFT_W-1:0];
	assign overlay_color_shift    = overlay_color_delay_q[VOFS_SHIFT_W-1:0];
	assign component_video_shift  = component_video_delay_q[VOFS_SHIFT_W-1:0];

	// ------------------------------------------------------------
	// input routing decode
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			comb_input_q    <= 1'b0;
			comp_is_ypbpr_q <= 1'b0;
			comp_bank_q     <= VOFS_BANK_NONE;
		end else begin
			comb_input_q    <= 1'b1;
			comp_is_ypbpr_q <= 1'b0;
			if (input_source_select_q == VOFS_SEL_RGB_A) begin
				comp_bank_q <= VOFS_BANK_A;
			end else if (input_source_select_q == VOFS_SEL_RGB_B) begin
				comp_bank_q <= VOFS_BANK_B;
			end else if (input_source_select_q == VOFS_SEL_RGB_C) begin
				comp_bank_q <= VOFS_BANK_C;
			end else if (input_source_select_q == VOFS_SEL_YPBPR_A) begin
				comp_bank_q     <= VOFS_BANK_A;
				comp_is_ypbpr_q <= 1'b1;
			end else if (input_source_select_q == VOFS_SEL_YPBPR_B) begin
				comp_bank_q     <= VOFS_BANK_B;
				comp_is_ypbpr_q <= 1'b1;
			end else if (input_source_select_q == VOFS_SEL_YPBPR_C) begin
				comp_bank_q     <= VOFS_BANK_C;
				comp_is_ypbpr_q <= 1'b1;
			end else begin
				comp_bank_q  <= VOFS_BANK_NONE;
				comb_input_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// alignment history
	// ------------------------------------------------------------
	vofs_hist_t hist_q [VOFS_HIST_DEPTH];
	logic       accept;
	vofs_hist_t hist_in;

	assign accept = in_valid && in_ready_q;

	always_comb begin
		hist_in.cvbs  = in_video.cvbs;
		hist_in.comp  = in_video.comp;
		hist_in.color = {overlay_red_in, overlay_green_in,
			overlay_blue_in};
		hist_in.osw   = overlay_switch_in;
		hist_in.csw   = component_switch_in;
	end

	always_ff @(posedge clk) begin
		if (accept) begin
			hist_q[0] <= hist_in;
			for (int i = 1; i < VOFS_HIST_DEPTH; i++) begin
				hist_q[i] <= hist_q[i-1];
			end
		end
	end

	// ------------------------------------------------------------
	// tap selection
	// ------------------------------------------------------------
	logic [VOFS_TAP_W-1:0] tap_cvbs;
	logic [VOFS_TAP_W-1:0] tap_comp;
	logic [VOFS_TAP_W-1:0] tap_color;
	logic [VOFS_TAP_W-1:0] tap_osw;
	logic [VOFS_TAP_W-1:0] tap_csw;
	logic [6:0]            color_base;
	logic [6:0]            comp_base;

	assign tap_cvbs   = VOFS_TAP_BASE[VOFS_TAP_W-1:0];
	assign tap_comp   = tap_of(VOFS_TAP_BASE, component_video_shift);
	assign tap_color  = tap_of(VOFS_TAP_BASE, overlay_color_shift);
	assign color_base = {1'b0, tap_color};
	assign comp_base  = {1'b0, tap_comp};
	// a late edge takes the older sample of the switch
	assign tap_osw = tap_of(color_base, overlay_switch_shift)
		+ {{(VOFS_TAP_W-1){1'b0}}, osw_late};
	assign tap_csw = tap_of(comp_base, component_switch_shift)
		+ {{(VOFS_TAP_W-1){1'b0}}, csw_late};

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	logic        ovl_on;
	logic        cmp_on;
	vofs_pixel_t px_cvbs;
	vofs_pixel_t px_comp;
	vofs_pixel_t px_ovl;
	vofs_pixel_t px_mix;
	vofs_pixel_t px_sel;

	assign ovl_on = sw_active(hist_q[tap_osw].osw, osw_pol)
		&& out_fmt_10bit;
	assign cmp_on = sw_active(hist_q[tap_csw].csw, csw_pol);

	always_comb begin
		px_cvbs.src   = VOFS_SRC_CVBS;
		px_cvbs.data  = hist_q[tap_cvbs].cvbs;
		px_cvbs.color = 3'h0;
		px_comp.src   = VOFS_SRC_COMP;
		px_comp.data  = hist_q[tap_comp].comp;
		px_comp.color = 3'h0;
		px_ovl.src    = VOFS_SRC_OVERLAY;
		px_ovl.data   = 10'h000;
		px_ovl.color  = hist_q[tap_color].color;
		px_mix        = px_cvbs;
		px_sel        = px_cvbs;
		case (mode)
			VOFS_MODE_CVBS_COMP: begin
				px_sel = cmp_on ? px_comp : px_cvbs;
			end
			VOFS_MODE_CVBS_OVL: begin
				px_sel = ovl_on ? px_ovl : px_cvbs;
			end
			VOFS_MODE_COMP_OVL: begin
				px_sel = ovl_on ? px_ovl : px_comp;
			end
			VOFS_MODE_MIX_THEN_OVL: begin
				px_mix = cmp_on ? px_comp : px_cvbs;
				px_sel = ovl_on ? px_ovl : px_mix;
			end
			VOFS_MODE_OVL_THEN_CMP: begin
				px_mix = ovl_on ? px_ovl : px_cvbs;
				px_sel = cmp_on ? px_comp : px_mix;
			end
			VOFS_MODE_CVBS_OR_MIX: begin
				px_mix = ovl_on ? px_ovl : px_comp;
				px_sel = cmp_on ? px_mix : px_cvbs;
			end
			VOFS_MODE_COMP_ONLY: begin
				px_sel = px_comp;
			end
			default: begin
				px_sel = px_cvbs;
			end
		endcase
	end

	// ------------------------------------------------------------
	// selection stage
	// ------------------------------------------------------------
	logic        sel_valid_q;
	vofs_pixel_t sel_pixel_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_valid_q <= 1'b0;
		end else begin
			sel_valid_q <= accept;
		end
	end

	always_ff @(posedge clk) begin
		if (accept) begin
			sel_pixel_q <= px_sel;
		end
	end

	// ------------------------------------------------------------
	// two-entry output buffer
	// ------------------------------------------------------------
	logic        skid_valid_q;
	vofs_pixel_t skid_pixel_q;
	logic        head_free;
	logic        out_valid_d;
	logic        skid_valid_d;
	logic [1:0]  fill_d;

	assign head_free = !out_valid_q || out_ready;

	always_comb begin
		out_valid_d  = out_valid_q;
		skid_valid_d = skid_valid_q;
		if (head_free) begin
			out_valid_d  = skid_valid_q || sel_valid_q;
			skid_valid_d = skid_valid_q && sel_valid_q;
		end else if (sel_valid_q) begin
			skid_valid_d = 1'b1;
		end
		fill_d = {1'b0, out_valid_d} + {1'b0, skid_valid_d}
			+ {1'b0, accept};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_valid_q  <= 1'b0;
			skid_valid_q <= 1'b0;
			in_ready_q   <= 1'b0;
		end else begin
			out_valid_q  <= out_valid_d;
			skid_valid_q <= skid_valid_d;
			in_ready_q   <= fill_d < VOFS_BUF_FULL;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_pixel_q  <= '0;
			skid_pixel_q <= '0;
		end else if (head_free) begin
			if (skid_valid_q) begin
				out_pixel_q  <= skid_pixel_q;
				skid_pixel_q <= sel_pixel_q;
			end else if (sel_valid_q) begin
				out_pixel_q <= sel_pixel_q;
			end
		end else if (sel_valid_q) begin
			skid_pixel_q <= sel_pixel_q;
		end
	end

endmodule

// >>> hdl/vofs_pkg.sv
// package: constants and types of the video overlay fast switch
package vofs_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] VOFS_ADDR_INPUT_SEL   = 8'h00;
	localparam logic [7:0] VOFS_ADDR_FS_CTRL     = 8'h28;
	localparam logic [7:0] VOFS_ADDR_OSW_SHIFT   = 8'h29;
	localparam logic [7:0] VOFS_ADDR_CSW_SHIFT   = 8'h2A;
	localparam logic [7:0] VOFS_ADDR_COLOR_SHIFT = 8'h2B;
	localparam logic [7:0] VOFS_ADDR_COMP_SHIFT  = 8'h2C;

	localparam logic [7:0] VOFS_RST_INPUT_SEL = 8'h00;
	localparam logic [7:0] VOFS_RST_FS_CTRL   = 8'hCC;
	localparam logic [7:0] VOFS_RST_SHIFT     = 8'h00;

	// writable bit masks, reserved bits read as zero
	localparam logic [7:0] VOFS_MASK_FS_CTRL = 8'hEF;
	localparam logic [7:0] VOFS_MASK_SHIFT   = 8'h1F;

	// ------------------------------------------------------------
	// fast-switch control fields
	// ------------------------------------------------------------
	localparam int VOFS_MODE_MSB      = 7;
	localparam int VOFS_MODE_LSB      = 5;
	localparam int VOFS_OSW_EDGE_BIT  = 3;
	localparam int VOFS_CSW_EDGE_BIT  = 2;
	localparam int VOFS_OSW_POL_BIT   = 1;
	localparam int VOFS_CSW_POL_BIT   = 0;
	localparam int VOFS_SHIFT_W       = 5;

	localparam logic [2:0] VOFS_MODE_CVBS_COMP    = 3'h0;
	localparam logic [2:0] VOFS_MODE_CVBS_OVL     = 3'h1;
	localparam logic [2:0] VOFS_MODE_COMP_OVL     = 3'h2;
	localparam logic [2:0] VOFS_MODE_MIX_THEN_OVL = 3'h3;
	localparam logic [2:0] VOFS_MODE_OVL_THEN_CMP = 3'h4;
	localparam logic [2:0] VOFS_MODE_CVBS_OR_MIX  = 3'h5;
	localparam logic [2:0] VOFS_MODE_CVBS_ONLY    = 3'h6;
	localparam logic [2:0] VOFS_MODE_COMP_ONLY    = 3'h7;

	// ------------------------------------------------------------
	// input-select codes for combined composite and component
	// ------------------------------------------------------------
	localparam logic [7:0] VOFS_SEL_RGB_A   = 8'hCC;
	localparam logic [7:0] VOFS_SEL_RGB_B   = 8'hCD;
	localparam logic [7:0] VOFS_SEL_RGB_C   = 8'hCE;
	localparam logic [7:0] VOFS_SEL_YPBPR_A = 8'hDC;
	localparam logic [7:0] VOFS_SEL_YPBPR_B = 8'hDD;
	localparam logic [7:0] VOFS_SEL_YPBPR_C = 8'hDE;

	localparam logic [1:0] VOFS_BANK_A    = 2'h0;
	localparam logic [1:0] VOFS_BANK_B    = 2'h1;
	localparam logic [1:0] VOFS_BANK_C    = 2'h2;
	localparam logic [1:0] VOFS_BANK_NONE = 2'h3;

	// ------------------------------------------------------------
	// alignment buffer
	// ------------------------------------------------------------
	localparam int         VOFS_HIST_DEPTH = 64;
	localparam int         VOFS_TAP_W      = 6;
	localparam logic [6:0] VOFS_TAP_BASE   = 7'h20;
	localparam logic [1:0] VOFS_BUF_FULL   = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		VOFS_SRC_CVBS,
		VOFS_SRC_COMP,
		VOFS_SRC_OVERLAY
	} vofs_src_t;

	typedef struct packed {
		logic [9:0] cvbs;
		logic [9:0] comp;
	} vofs_video_t;

	typedef struct packed {
		logic [9:0] cvbs;
		logic [9:0] comp;
		logic [2:0] color;
		logic       osw;
		logic       csw;
	} vofs_hist_t;

	typedef struct packed {
		vofs_src_t  src;
		logic [9:0] data;
		logic [2:0] color;
	} vofs_pixel_t;

endpackage

// >>> tb/video_overlay_fast_switch_test.sv
// testbench: registers, modes, delays and stalls of the fast switch
`timescale 1ns/1ps
module video_overlay_fast_switch_test;
	import vofs_pkg::*;
	logic        clk, arst_n, reg_wr_en, reg_rd_en, out_fmt_10bit;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, step_at, count;
	logic        in_valid, in_ready_q, osw, csw, out_valid_q, out_ready;
	logic        comb_input_q, comp_is_ypbpr_q, run, done, stall, dropped;
	logic [1:0]  comp_bank_q;
	logic [2:0]  color;
	vofs_video_t in_video;
	vofs_pixel_t out_pixel_q;
	vofs_hist_t  pre_h, post_h;
	logic        waited;
	vofs_pixel_t log [256];
	int          n_out, cyc, num_errors, total_checks;

	vofs_fast_switch u_dut (
		.clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .out_fmt_10bit(out_fmt_10bit),
		.in_valid(in_valid), .in_ready_q(in_ready_q), .in_video(in_video),
		.overlay_red_in(color[2]), .overlay_green_in(color[1]),
		.overlay_blue_in(color[0]), .overlay_switch_in(osw),
		.component_switch_in(csw), .out_valid_q(out_valid_q),
		.out_ready(out_ready), .out_pixel_q(out_pixel_q),
		.comb_input_q(comb_input_q), .comp_is_ypbpr_q(comp_is_ypbpr_q),
		.comp_bank_q(comp_bank_q));
	vofs_osd_model u_src (
		.clk(clk), .arst_n(arst_n), .run(run), .step_at(step_at),
		.count(count), .pre_h(pre_h), .post_h(post_h), .done(done),
		.in_ready_q(in_ready_q), .in_valid(in_valid), .in_video(in_video),
		.color(color), .osw(osw), .csw(csw));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (out_valid_q && out_ready) begin
			log[n_out] = out_pixel_q;
			n_out++;
		end
		if (in_valid && !in_ready_q && waited)
			dropped = 1'b1;
		waited = in_valid && !in_ready_q;
	end
	always @(negedge clk) begin
		cyc++;
		out_ready <= !(stall && cyc % 5 < 3);
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		d = reg_rdata_q;
	endtask
	task automatic stream(input logic [7:0] n, k, input vofs_hist_t b, a);
		int t;
		@(negedge clk);
		count <= n;
		step_at <= k;
		pre_h <= b;
		post_h <= a;
		n_out = 0;
		dropped = 1'b0;
		run <= 1'b1;
		for (t = 0; t < 3000 && n_out < n; t++)
			@(negedge clk);
		run <= 1'b0;
		check("pixel count", 16'(n_out), 16'(n));
	endtask
	function automatic vofs_hist_t hv(input logic [9:0] cp,
		input logic [2:0] c, input logic o, s);
		hv = {10'h2A5, cp, c, o, s};
	endfunction
	function automatic vofs_pixel_t exp_pix(input logic [2:0] m,
		input logic p, f, input vofs_hist_t h);
		logic       o;
		logic       c;
		logic [1:0] s;
		o = h.osw == p && f;
		c = h.csw == !p;
		case (m)
			3'h0: s = c ? 2'h1 : 2'h0;
			3'h1: s = o ? 2'h2 : 2'h0;
			3'h2: s = o ? 2'h2 : 2'h1;
			3'h3: s = o ? 2'h2 : {1'h0, c};
			3'h4: s = c ? 2'h1 : {o, 1'h0};
			3'h5: s = c ? (o ? 2'h2 : 2'h1) : 2'h0;
			3'h7: s = 2'h1;
			default: s = 2'h0;
		endcase
		exp_pix = {s, s == 2'h0 ? h.cvbs : s == 2'h1 ? h.comp : 10'h000,
			s == 2'h2 ? h.color : 3'h0};
	endfunction

	task automatic test_regs;
		logic [7:0] d;
		logic [7:0] ad [6];
		logic [7:0] rv [6];
		logic [7:0] mk [6];
		int         i;
		ad = '{8'h00, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C};
		rv = '{8'h00, 8'hCC, 8'h00, 8'h00, 8'h00, 8'h00};
		mk = '{8'hFF, 8'hEF, 8'h1F, 8'h1F, 8'h1F, 8'h1F};
		for (i = 0; i < 6; i++) begin
			rd_reg(ad[i], d);
			check("reset value", d, rv[i]);
			wr_reg(ad[i], 8'hFF);
			rd_reg(ad[i], d);
			check("masked write", d, mk[i]);
			wr_reg(ad[i], rv[i]);
		end
		wr_reg(8'h30, 8'h5A);
		rd_reg(8'h30, d);
		check("unmapped read", d, 8'h00);
	endtask
	task automatic test_sel;
		logic [7:0] cd [7];
		int         i;
		cd = '{8'hCC, 8'hCD, 8'hCE, 8'hDC, 8'hDD, 8'hDE, 8'h0C};
		for (i = 0; i < 7; i++) begin
			wr_reg(VOFS_ADDR_INPUT_SEL, cd[i]);
			@(negedge clk);
			check("select",
				{comb_input_q, comp_is_ypbpr_q, comp_bank_q},
				i < 6 ? {1'h1, 1'(i > 2), 2'(i % 3)} : 4'h3);
		end
	endtask
	task automatic test_modes;
		vofs_hist_t h;
		int         i;
		for (i = 0; i < 128; i++) begin
			h = hv(10'h15A, 3'(i + i / 8), i[1], i[0]);
			wr_reg(VOFS_ADDR_FS_CTRL, {i[5:3], 3'h0, i[2], !i[2]});
			out_fmt_10bit = !i[6];
			stall = i == 45;
			stream(8'h46, 8'hFF, h, h);
			check("mode pixel",
				16'(log[69]), 16'(exp_pix(i[5:3], i[2], !i[6], h)));
			if (stall)
				check("ready drop", 16'(dropped), 16'h1);
		end
		stall = 1'b0;
		out_fmt_10bit = 1'b1;
	endtask
	task automatic test_delay(input logic [7:0] ctrl, a, sh,
		input vofs_hist_t b, af, input int tap);
		int i;
		wr_reg(VOFS_ADDR_FS_CTRL, ctrl);
		wr_reg(a, sh);
		stream(8'hA0, 8'h50, b, af);
		for (i = 64; i < 159 && log[i] === log[64]; i++);
		check("step index", 16'(i), 16'(81 + tap));
		wr_reg(a, 8'h00);
	endtask

	initial begin
		{reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
		{run, stall, waited, step_at, count, pre_h, post_h} = '0;
		{cyc, n_out, num_errors, total_checks} = '0;
		out_fmt_10bit = 1'b1;
		out_ready = 1'b1;
		arst_n = 1'b0;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		test_regs;
		$display("done: registers");
		test_sel;
		$display("done: input select");
		test_modes;
		$display("done: modes");
		test_delay(8'h22, 8'h29, 8'h10, hv(10'h15A, 3'h3, 1'h0, 1'h0),
			hv(10'h15A, 3'h3, 1'h1, 1'h0), 16);
		test_delay(8'h2A, 8'h29, 8'h0F, hv(10'h15A, 3'h3, 1'h0, 1'h0),
			hv(10'h15A, 3'h3, 1'h1, 1'h0), 48);
		test_delay(8'h05, 8'h2A, 8'h1F, hv(10'h15A, 3'h0, 1'h0, 1'h0),
			hv(10'h15A, 3'h0, 1'h0, 1'h1), 32);
		test_delay(8'h22, 8'h2B, 8'h0F, hv(10'h15A, 3'h1, 1'h1, 1'h0),
			hv(10'h15A, 3'h6, 1'h1, 1'h0), 47);
		test_delay(8'hE0, 8'h2C, 8'h10, hv(10'h100, 3'h0, 1'h0, 1'h0),
			hv(10'h0FF, 3'h0, 1'h0, 1'h0), 16);
		$display("done: delays");
		complete_run;
	end
	initial begin
		#1000000;
		num_errors++;
		$display("watchdog expired");
		complete_run;
	end
endmodule

// >>> tb/vofs_fast_switch_checker.sv
// checker: port assertions of the fast switch
`timescale 1ns/1ps
module vofs_fast_switch_checker (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  arst_n,
	// register port
	input wire logic                  reg_wr_en,
	input wire logic                  reg_rd_en,
	input wire logic [7:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic [7:0]            reg_rdata_q,
	// pixel path
	input wire logic                  out_fmt_10bit,
	input wire logic                  out_valid_q,
	input wire logic                  out_ready,
	input wire vofs_pkg::vofs_pixel_t out_pixel_q,
	// routing status
	input wire logic                  comb_input_q,
	input wire logic                  comp_is_ypbpr_q,
	input wire logic [1:0]            comp_bank_q
);
	import vofs_pkg::*;
	logic [2:0] mode_q;
	logic       mapped;
	logic       ovl;
	assign mapped = reg_addr inside {8'h00, [8'h28:8'h2C]};
	assign ovl = out_valid_q && out_pixel_q.src == VOFS_SRC_OVERLAY;
	// mode snooped from control writes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= VOFS_MODE_CVBS_ONLY;
		end else if (reg_wr_en && reg_addr == VOFS_ADDR_FS_CTRL) begin
			mode_q <= reg_wdata[VOFS_MODE_MSB:VOFS_MODE_LSB];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_CTRL_RSVD: assert property (
		reg_rd_en && reg_addr == VOFS_ADDR_FS_CTRL |=> !reg_rdata_q[4])
		else $error("control reserved bit reads one");
	AST_SHIFT_RSVD: assert property (
		reg_rd_en && reg_addr inside {[8'h29:8'h2C]}
		|=> reg_rdata_q[7:5] == 3'h0) else $error("shift upper bits set");
	AST_UNMAPPED: assert property (
		reg_rd_en && !mapped |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	AST_NARROW_NO_OVL: assert property (
		(!out_fmt_10bit) [*4] |-> !ovl)
		else $error("overlay shown in narrow format");
	AST_PIX_FIELDS: assert property (
		out_valid_q |-> (ovl ? out_pixel_q.data == 10'h000
		: out_pixel_q.color == 3'h0)) else $error("pixel fields mixed");
	AST_OUT_HOLD: assert property (
		out_valid_q && !out_ready |=> out_valid_q && $stable(out_pixel_q))
		else $error("stalled pixel changed");
	AST_COMP_ONLY: assert property (
		mode_q == 3'h7 && out_valid_q |-> out_pixel_q.src == VOFS_SRC_COMP)
		else $error("component only mode left component");
	AST_CVBS_ONLY: assert property (
		mode_q == 3'h6 && out_valid_q |-> out_pixel_q.src == VOFS_SRC_CVBS)
		else $error("composite only mode left composite");
	AST_MODE0_NO_OVL: assert property (
		mode_q == 3'h0 |-> !ovl) else $error("overlay in mode zero");
	AST_MODE1_NO_COMP: assert property (
		mode_q == 3'h1 && out_valid_q |-> out_pixel_q.src != VOFS_SRC_COMP)
		else $error("component in mode one");
	AST_SEL_RGB: assert property (
		reg_wr_en && reg_addr == 8'h00 && reg_wdata == VOFS_SEL_RGB_B
		|-> ##[1:2] comb_input_q && !comp_is_ypbpr_q
		&& comp_bank_q == VOFS_BANK_B) else $error("rgb select decode");
	AST_SEL_YPBPR: assert property (
		reg_wr_en && reg_addr == 8'h00 && reg_wdata == VOFS_SEL_YPBPR_C
		|-> ##[1:2] comb_input_q && comp_is_ypbpr_q
		&& comp_bank_q == VOFS_BANK_C) else $error("ypbpr select decode");
	COV_MIX_OVL: cover property (ovl && mode_q == 3'h3);
	COV_STALL: cover property (out_valid_q && !out_ready);
	COV_UNMAPPED: cover property (reg_rd_en && !mapped);
endmodule

bind vofs_fast_switch vofs_fast_switch_checker u_chk (
	.clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
	.reg_rdata_q, .out_fmt_10bit, .out_valid_q, .out_ready,
	.out_pixel_q, .comb_input_q, .comp_is_ypbpr_q, .comp_bank_q
);

// >>> tb/vofs_osd_model.sv
// model: overlay source stepping video, colors and switches
`timescale 1ns/1ps
module vofs_osd_model (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// run control
	input  wire logic                 run,
	input  wire logic [7:0]           step_at,
	input  wire logic [7:0]           count,
	input  wire vofs_pkg::vofs_hist_t pre_h,
	input  wire vofs_pkg::vofs_hist_t post_h,
	output logic                      done,
	// pins toward the decoder
	input  wire logic                 in_ready_q,
	output logic                      in_valid,
	output vofs_pkg::vofs_video_t     in_video,
	output logic [2:0]                color,
	output logic                      osw,
	output logic                      csw
);
	import vofs_pkg::*;
	logic [7:0] idx;
	logic       took;
	vofs_hist_t cur;
	assign {in_video, color, osw, csw} = cur;
	always @(posedge clk) begin
		took <= in_valid && in_ready_q;
	end
	// pins move on the falling edge only, in step with the pixel clock
	always @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idx = 8'h00;
			in_valid = 1'b0;
			done = 1'b0;
			cur = '0;
		end else begin
			if (took)
				idx = idx + 8'h01;
			if (!run)
				idx = 8'h00;
			done = run && idx == count;
			in_valid = run && !done;
			// idle pins toggle so a stale pixel is never mistaken
			cur = !in_valid ? ~cur : (idx < step_at ? pre_h : post_h);
		end
	end
endmodule
